// >>> bench/i2sm_chk.sv
// pin-level assertions for the i2c to spi bridge top
`default_nettype none
module i2sm_chk (
    input wire logic ref_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic scl_in, // i2c clock level
    input wire logic sda_in, // i2c data level
    input wire logic scl_oe, // scl stretch drive
    input wire logic sda_oe, // sda pull drive
    input wire logic scl_out, // scl drive value
    input wire logic sda_out, // sda drive value
    input wire logic spi_clock_out, // spi clock
    input wire logic slave_select_0, // select 0
    input wire logic slave_select_1, // select 1
    input wire logic slave_select_2, // select 2
    input wire logic slave_select_3, // select 3
    input wire logic irq_n // interrupt, active low
);
    // selects gathered so one reduction tells idle from busy
    wire logic [3:0] ss = {slave_select_3, slave_select_2,
        slave_select_1, slave_select_0};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence sel_opens;
        $fell(&ss);
    endsequence
    sequence sel_closes;
        $rose(&ss);
    endsequence
    a_reset_idle: assert property (disable iff (1'b0)
        !rst_b |=> &ss && irq_n && !scl_oe && !sda_oe)
        else $error("outputs not idle after reset");
    a_clk_after_sel: assert property (
        sel_opens |-> ##1 $stable(spi_clock_out) [*3])
        else $error("spi clock moved right after select");
    a_sel_held: assert property (sel_opens |-> !(&ss) [*8])
        else $error("select released too early");
    a_sel_steady: assert property (
        !(&ss) && !(&$past(ss)) |-> $stable(ss))
        else $error("select set changed mid transfer");
    a_end_sets_irq: assert property (sel_closes |-> !irq_n)
        else $error("no interrupt at transfer end");
    a_irq_only_end: assert property ($fell(irq_n) |-> sel_closes)
        else $error("interrupt not tied to transfer end");
    a_irq_clear_idle: assert property (
        $rose(irq_n) |-> &ss && scl_in && sda_in)
        else $error("interrupt cleared outside a stop");
    a_stretch_short: assert property (
        $rose(scl_oe) |-> ##[1:8] !scl_oe)
        else $error("scl held low too long");
    a_od_low_only: assert property (!scl_out && !sda_out)
        else $error("open-drain pin driven high");
endmodule : i2sm_chk
bind i2sm_top i2sm_chk chk (.ref_clk, .rst_b, .scl_in, .sda_in, .scl_oe,
    .sda_oe, .scl_out, .sda_out, .spi_clock_out, .slave_select_0,
    .slave_select_1, .slave_select_2, .slave_select_3, .irq_n);
`default_nettype wire

// >>> bench/i2sm_host.sv
// i2c master model standing in for the host microcontroller
`default_nettype none
module i2sm_host import i2sm_pkg::*; (
    input wire logic ref_clk, // bench clock
    input wire logic scl, // resolved scl level
    input wire logic sda, // resolved sda level
    output logic scl_l, // high pulls scl low
    output logic sda_l // high pulls sda low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {scl_l, sda_l} = 2'b00;
    // one bit: 4 cycles low, wait out a stretch, 4 cycles high
    task automatic bit_slot(input logic b, output logic r);
        scl_l = 1'b1;
        @(negedge ref_clk);
        sda_l = !b;
        repeat (3) @(negedge ref_clk);
        scl_l = 1'b0;
        for (int i = 0; i < 99 && !scl; i++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        r = sda;
    endtask : bit_slot
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
        bit_slot(1'b1, r);
        ack = !r;
    endtask : wbyte
    // master nacks the last byte so the slave lets go of sda
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
        bit_slot(last, r);
    endtask : rbyte
    // whole message; a refused address skips the payload
    task automatic msg(input logic rd, inout logic [7:0] q[$],
        output logic ack);
        logic r;
        sda_l = 1'b1;
        repeat (4) @(negedge ref_clk);
        wbyte({I2C_ADDR, rd}, ack);
        if (ack)
            foreach (q[i])
                if (rd) rbyte(i == q.size() - 1, q[i]);
                else wbyte(q[i], r);
        bit_slot(1'b0, r);
        sda_l = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : msg
endmodule : i2sm_host
`default_nettype wire

// >>> bench/tb.sv
// bench: host model on i2c, spi slave here, four mode and rate rounds
`default_nettype none
module tb import i2sm_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_b = 1'b0, tog = 1'b0, sp = 1'b0;
    logic scl_l, sda_l, scl_oe, sda_oe, sclk, mosi, irq_n, ack;
    logic [3:0] ss;
    logic [25:0] tx_pat = 26'h0;
    logic [23:0] rx_cap, txd;
    logic [7:0] q[$];
    int seed = 4, failures = 0, n_tests = 0, e = 0, cnt = 0, hp, cpha;
    wire logic scl = !scl_l && (scl_oe !== 1'b1);
    wire logic sda = !sda_l && (sda_oe !== 1'b1);
    // a deselected slave leaves miso toggling, never a stale bit
    wire logic miso = (ss === 4'b1011) ? tx_pat[24 - (e + cpha) / 2 + cpha]
        : tog;
    i2sm_top dut (.ref_clk, .rst_b, .scl_in(scl), .scl_out(), .scl_oe,
        .sda_in(sda), .sda_out(), .sda_oe, .spi_clock_out(sclk), .mosi,
        .miso, .slave_select_0(ss[0]), .slave_select_1(ss[1]),
        .slave_select_2(ss[2]), .slave_select_3(ss[3]), .irq_n);
    i2sm_host host (.ref_clk, .scl, .sda, .scl_l, .sda_l);
    always #20 ref_clk = !ref_clk;
    // spi slave: counts edges, samples mosi, times the half period
    always @(negedge ref_clk)
    begin
        sp <= sclk;
        tog <= !tog;
        cnt <= (sclk != sp) ? 1 : cnt + 1;
        if (ss !== 4'b1011) e <= 0;
        else if (sclk != sp)
        begin
            e <= e + 1;
            if (e == 1) hp <= cnt;
            if (e % 2 == cpha) rx_cap <= {rx_cap[22:0], mosi};
        end
    end
    function automatic logic [8:0] half_of(input logic [1:0] r);
        return r == 0 ? HALF_R0 : r == 1 ? HALF_R1 : r == 2 ? HALF_R2 : HALF_R3;
    endfunction : half_of
    task automatic cmp(input string nm, input logic [23:0] exp, got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : cmp
    task automatic test_done;
        $display("comparisons %0d, failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial
    begin
        logic [7:0] cfg;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        cmp("idle pins", 24'h1f, 24'({irq_n, ss}));
        // round 0 is setting 02; the four rounds together reach every mode and rate
        for (int i = 0; i < 4; i++)
        begin
            cfg = 8'({i[1:0], i[1:0] ^ 2'b10});
            cpha = int'(cfg[2]);
            q = {FID_CFG, cfg};
            host.msg(1'b0, q, ack);
            txd = 24'($random(seed));
            if (i == 0) txd[7:0] = FILL_BYTE;
            tx_pat = 26'($random(seed));
            // last round frees select 0 as gpio yet names it; it stays high
            if (i == 3)
            begin
                q = {FID_GPEN, 8'h01};
                host.msg(1'b0, q, ack);
            end
            q = {8'h04 | 8'(i == 3), txd[23:16], txd[15:8], txd[7:0]};
            host.msg(1'b0, q, ack);
            q = {FID_CLR};
            host.msg(1'b0, q, ack);
            cmp("ack while busy", 24'h0, 24'(ack));
            for (int t = 0; t < 20000 && irq_n; t++) @(negedge ref_clk);
            cmp("mosi bytes", txd, rx_cap);
            cmp("half period", 24'(half_of(cfg[1:0])), 24'(hp));
            cmp("irq after transfer", 24'h0, 24'(irq_n));
            q = {FID_CLR};
            host.msg(1'b0, q, ack);
            repeat (4) @(negedge ref_clk);
            cmp("irq after clear", 24'h1, 24'(irq_n));
            q = {8'h00, 8'h00, 8'h00};
            host.msg(1'b1, q, ack);
            cmp("buffer", tx_pat[24:1], {q[0], q[1], q[2]});
            $display("round %0d done", i);
        end
        test_done();
    end
    // longest round is under 20000 cycles; allow 60000 in all
    initial
    begin
        #2400000;
        failures++;
        test_done();
    end
endmodule : tb
`default_nettype wire

// >>> core/i2sm_pkg.sv
// shared constants and types of the i2c-to-spi master transfer path
`default_nettype none
package i2sm_pkg;
    // processor clock; stands in for the external clock input
    localparam int CLK_HZ = 25_000_000;
    // spi bit rates selected by the two low setting bits
    localparam int RATE0_BPS = 4_000_000;
    localparam int RATE1_BPS = 1_000_000;
    localparam int RATE2_BPS = 115_000;
    localparam int RATE3_BPS = 58_000;
    // half bit periods in ref_clk cycles, rounded up so no rate is exceeded
    localparam logic [8:0] HALF_R0 =
        9'((CLK_HZ + 2 * RATE0_BPS - 1) / (2 * RATE0_BPS));
    localparam logic [8:0] HALF_R1 =
        9'((CLK_HZ + 2 * RATE1_BPS - 1) / (2 * RATE1_BPS));
    localparam logic [8:0] HALF_R2 =
        9'((CLK_HZ + 2 * RATE2_BPS - 1) / (2 * RATE2_BPS));
    localparam logic [8:0] HALF_R3 =
        9'((CLK_HZ + 2 * RATE3_BPS - 1) / (2 * RATE3_BPS));
    // 7-bit i2c slave address
    localparam logic [6:0] I2C_ADDR = 7'h28;
    // function identifiers
    localparam logic [7:0] FID_CFG = 8'hf0;
    localparam logic [7:0] FID_CLR = 8'hf1;
    localparam logic [7:0] FID_GPEN = 8'hf6;
    // data buffer length in bytes
    localparam logic [7:0] BUF_LEN = 8'hc8;
    // filler returned when reading past the buffer
    localparam logic [7:0] FILL_BYTE = 8'hff;
    // reset values
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam logic [3:0] GPEN_RESET = 4'h0;
    localparam logic [3:0] SEL_IDLE = 4'hf;
    // scl low hold after each received write byte, in cycles
    localparam logic [2:0] STRETCH_CYC = 3'h4;
    // spi edges per byte
    localparam logic [4:0] EDGES_BYTE = 5'h10;

    typedef enum logic [1:0] {
        IS_IDLE = 2'b00,
        IS_ADDR = 2'b01,
        IS_WR = 2'b10,
        IS_RD = 2'b11
    } i2sm_i2c_type;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_LEAD = 2'b01,
        SQ_BYTE = 2'b10,
        SQ_TAIL = 2'b11
    } i2sm_seq_type;
endpackage : i2sm_pkg
`default_nettype wire

// >>> core/i2sm_spi_byte.sv
// spi byte shifter: one byte out on mosi, one in from miso, all four modes
`default_nettype none
module i2sm_spi_byte import i2sm_pkg::*; (
    input wire logic ref_clk, // processor clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic start, // one-cycle pulse, begins a byte
    input wire logic [7:0] tx_byte, // byte to send, taken with start
    input wire logic cpol, // idle level of the spi clock
    input wire logic cpha, // 1: data launched on leading edge
    input wire logic [8:0] half_cyc, // half bit period in cycles
    input wire logic miso_s, // synchronised miso
    output logic sclk, // spi clock out
    output logic mosi, // serial data out
    output logic [7:0] rx_byte, // byte captured from miso
    output logic done // one-cycle pulse, byte finished
);
    logic run_reg;
    logic [4:0] edge_reg;
    logic [8:0] tmr_reg;
    logic [7:0] tx_reg;
    logic launch;

    // launch edges are odd for phase 0 and even for phase 1
    assign launch = edge_reg[0] ^ cpha;

    // edge timer and shifting; the clock rests at cpol while idle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            run_reg <= 1'b0;
            edge_reg <= 5'h00;
            tmr_reg <= 9'h000;
            tx_reg <= 8'h00;
            sclk <= 1'b0;
            mosi <= 1'b0;
            rx_byte <= 8'h00;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!run_reg)
            begin
                sclk <= cpol;
                if (start)
                begin
                    run_reg <= 1'b1;
                    edge_reg <= 5'h00;
                    tmr_reg <= 9'h001;
                    // phase 0 presents bit 7 before the first edge
                    tx_reg <= cpha ? tx_byte : {tx_byte[6:0], 1'b0};
                    mosi <= cpha ? mosi : tx_byte[7];
                end
            end
            else if (tmr_reg != half_cyc)
            begin
                tmr_reg <= tmr_reg + 9'h001;
            end
            else if (edge_reg == EDGES_BYTE)
            begin
                // one extra half period keeps the last bit valid
                run_reg <= 1'b0;
                done <= 1'b1;
            end
            else
            begin
                tmr_reg <= 9'h001;
                edge_reg <= edge_reg + 5'h01;
                sclk <= ~sclk;
                if (launch)
                begin
                    mosi <= tx_reg[7];
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
                else
                begin
                    rx_byte <= {rx_byte[6:0], miso_s};
                end
            end
        end
    end
endmodule : i2sm_spi_byte
`default_nettype wire

// >>> core/i2sm_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`default_nettype none
module i2sm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk, // processor clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [WIDTH-1:0] d_in, // asynchronous pins
    output logic [WIDTH-1:0] q_out // synchronised copy
);
    logic [WIDTH-1:0] meta_reg;

    // idle level of every sampled line is high
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            meta_reg <= '1;
            q_out <= '1;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule : i2sm_sync
`default_nettype wire

// >>> core/i2sm_top.sv
// i2c slave front end, command decode, data buffer and spi master sequencer
// What this block does
// - runs from one processor clock taken from the external clock input
// - i2c bit rate unaffected; only the low hold between bytes varies
// - spi master supports clock polarity and phase modes 0 to 3
// - spi bit rate never exceeds the 4.0 Mbit/s ceiling
// - four separate active-low slave selects, any set of them chosen per transfer
// - the device generates the spi clock for every bit
// - data leaves on mosi and is sampled from miso
// - config code then one byte sets mode and rate; 02 gives 115 kHz
// - function id bits pick the select; following bytes go out on spi
// - a lone clear-interrupt code releases the pending interrupt
// - each received miso byte replaces its sent byte in the buffer
// - buffer read returns all captured bytes in order from the start
// - after reset all four pins act as selects until reassigned
`default_nettype none
module i2sm_top import i2sm_pkg::*; (
    input wire logic ref_clk, // processor clock, 25 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire logic scl_in, // i2c clock line level
    output logic scl_out, // i2c clock drive value, always low
    output logic scl_oe, // high while stretching scl low
    input wire logic sda_in, // i2c data line level
    output logic sda_out, // i2c data drive value, always low
    output logic sda_oe, // high while pulling sda low
    output logic spi_clock_out, // spi clock
    output logic mosi, // spi data out
    input wire logic miso, // spi data in
    output logic slave_select_0, // select 0, active low
    output logic slave_select_1, // select 1, active low
    output logic slave_select_2, // select 2, active low
    output logic slave_select_3, // select 3, active low
    output logic irq_n // transfer done interrupt, active low
);
    logic scl_s, sda_s, miso_s;
    logic scl_prev_reg, sda_prev_reg;
    logic start_det, stop_det, scl_rise, scl_fall;
    i2sm_i2c_type i2c_state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] sh_reg;
    logic ack_reg, first_reg, wr_stb_reg, stop_stb_reg;
    logic [7:0] rd_idx_reg, rd_byte;
    logic [2:0] stretch_reg;
    logic [7:0] fid_reg, wr_cnt_reg;
    logic [3:0] cfg_reg, gpen_reg;
    logic fid_is_spi, host_wr, launch_stb, clr_stb;
    logic [7:0] data_buf_reg [0:BUF_LEN-1];
    i2sm_seq_type seq_state_reg;
    logic [7:0] seq_idx_reg, seq_len_reg;
    logic [3:0] sel_reg;
    logic [8:0] gap_reg, half_cyc;
    logic busy_reg, eng_start_reg, eng_done, done_evt;
    logic [7:0] eng_tx_reg, eng_rx;
    logic [3:0] ss_n_reg;

    // scl_in, sda_in and miso pass two flops before use; rst_b is used directly
    i2sm_sync #(.WIDTH(3)) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d_in({scl_in, sda_in, miso}),
        .q_out({scl_s, sda_s, miso_s})
    );

    // bus events from the synchronised lines
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign rd_byte = (rd_idx_reg < BUF_LEN) ?
        data_buf_reg[rd_idx_reg] : FILL_BYTE;

    // i2c slave: address match, byte reception, buffer read-out
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            i2c_state_reg <= IS_IDLE;
            bit_cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            ack_reg <= 1'b0;
            first_reg <= 1'b0;
            wr_stb_reg <= 1'b0;
            stop_stb_reg <= 1'b0;
            rd_idx_reg <= 8'h00;
            sda_oe <= 1'b0;
        end
        else
        begin
            wr_stb_reg <= 1'b0;
            stop_stb_reg <= 1'b0;
            if (start_det || stop_det)
            begin
                // a repeated start also ends a write message
                stop_stb_reg <= (i2c_state_reg == IS_WR);
                i2c_state_reg <= start_det ? IS_ADDR : IS_IDLE;
                // the scl fall after a start carries no bit; it wraps to 0
                bit_cnt_reg <= start_det ? 4'hf : 4'h0;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (i2c_state_reg != IS_RD && bit_cnt_reg < 4'h8)
                    sh_reg <= {sh_reg[6:0], sda_s};
                // master nack ends the read
                if (i2c_state_reg == IS_RD && bit_cnt_reg == 4'h8 && sda_s)
                    i2c_state_reg <= IS_IDLE;
            end
            else if (scl_fall)
            begin
                case (i2c_state_reg)
                    IS_ADDR:
                    begin
                        if (bit_cnt_reg == 4'h7)
                        begin
                            // no ack while spi runs; host retries
                            ack_reg <= (sh_reg[7:1] == I2C_ADDR) && !busy_reg;
                            sda_oe <= (sh_reg[7:1] == I2C_ADDR) && !busy_reg;
                            bit_cnt_reg <= 4'h8;
                        end
                        else if (bit_cnt_reg == 4'h8)
                        begin
                            bit_cnt_reg <= 4'h0;
                            if (!ack_reg)
                            begin
                                i2c_state_reg <= IS_IDLE;
                                sda_oe <= 1'b0;
                            end
                            else if (sh_reg[0])
                            begin
                                // read always restarts at buffer byte 0
                                i2c_state_reg <= IS_RD;
                                sh_reg <= data_buf_reg[0];
                                sda_oe <= ~data_buf_reg[0][7];
                                rd_idx_reg <= 8'h01;
                            end
                            else
                            begin
                                i2c_state_reg <= IS_WR;
                                first_reg <= 1'b1;
                                sda_oe <= 1'b0;
                            end
                        end
                        else
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    IS_WR:
                    begin
                        if (bit_cnt_reg == 4'h7)
                        begin
                            sda_oe <= 1'b1;
                            wr_stb_reg <= 1'b1;
                            bit_cnt_reg <= 4'h8;
                        end
                        else if (bit_cnt_reg == 4'h8)
                        begin
                            sda_oe <= 1'b0;
                            first_reg <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                        end
                        else
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    IS_RD:
                    begin
                        if (bit_cnt_reg == 4'h7)
                        begin
                            sda_oe <= 1'b0;
                            bit_cnt_reg <= 4'h8;
                        end
                        else if (bit_cnt_reg == 4'h8)
                        begin
                            sh_reg <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            rd_idx_reg <= rd_idx_reg + 8'h01;
                            bit_cnt_reg <= 4'h0;
                        end
                        else
                        begin
                            sh_reg <= {sh_reg[6:0], 1'b0};
                            sda_oe <= ~sh_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    default:
                        bit_cnt_reg <= 4'h0;
                endcase
            end
        end
    end

    // scl held low briefly after each written byte while it is handed over;
    // the bit rate is untouched, only the inter-byte low lengthens
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            stretch_reg <= 3'h0;
        else if (scl_fall && i2c_state_reg == IS_WR && bit_cnt_reg == 4'h8)
            stretch_reg <= STRETCH_CYC;
        else if (stretch_reg != 3'h0)
            stretch_reg <= stretch_reg - 3'h1;
    end

    // open-drain pins only ever pull low
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= 1'b0;
        end
        else
        begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= (stretch_reg != 3'h0);
        end
    end

    assign fid_is_spi = (fid_reg[7:4] == 4'h0) && (fid_reg[3:0] != 4'h0);
    assign host_wr = wr_stb_reg && !first_reg && fid_is_spi &&
        (wr_cnt_reg < BUF_LEN);
    assign launch_stb = stop_stb_reg && !first_reg && fid_is_spi &&
        (wr_cnt_reg != 8'h00);
    assign clr_stb = stop_stb_reg && !first_reg && (fid_reg == FID_CLR) &&
        (wr_cnt_reg == 8'h00);

    // command decode: function id, setting bytes, payload count
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            fid_reg <= 8'h00;
            wr_cnt_reg <= 8'h00;
            cfg_reg <= CFG_RESET;
            gpen_reg <= GPEN_RESET;
        end
        else if (wr_stb_reg && first_reg)
        begin
            fid_reg <= sh_reg;
            wr_cnt_reg <= 8'h00;
        end
        else if (wr_stb_reg)
        begin
            if (fid_reg == FID_CFG && wr_cnt_reg == 8'h00)
                cfg_reg <= sh_reg[3:0];
            if (fid_reg == FID_GPEN && wr_cnt_reg == 8'h00)
                gpen_reg <= sh_reg[3:0];
            if (wr_cnt_reg != 8'hff)
                wr_cnt_reg <= wr_cnt_reg + 8'h01;
        end
    end

    // buffer: host payload in, captured miso bytes overwrite in place
    always_ff @(posedge ref_clk)
    begin
        if (host_wr)
            data_buf_reg[wr_cnt_reg] <= sh_reg;
        else if (eng_done)
            data_buf_reg[seq_idx_reg] <= eng_rx;
    end

    // setting bits 1:0 choose the rate; 02 is the 115 kHz setting
    always_comb
    begin
        case (cfg_reg[1:0])
            2'b00: half_cyc = HALF_R0;
            2'b01: half_cyc = HALF_R1;
            2'b10: half_cyc = HALF_R2;
            default: half_cyc = HALF_R3;
        endcase
    end

    // transfer sequencer: select lead, bytes back to back, select tail
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            seq_state_reg <= SQ_IDLE;
            seq_idx_reg <= 8'h00;
            seq_len_reg <= 8'h00;
            sel_reg <= 4'h0;
            gap_reg <= 9'h000;
            busy_reg <= 1'b0;
            eng_start_reg <= 1'b0;
            eng_tx_reg <= 8'h00;
        end
        else
        begin
            eng_start_reg <= 1'b0;
            case (seq_state_reg)
                SQ_IDLE:
                    if (launch_stb)
                    begin
                        seq_state_reg <= SQ_LEAD;
                        busy_reg <= 1'b1;
                        // pins taken over as gpio never assert
                        sel_reg <= fid_reg[3:0] & ~gpen_reg;
                        seq_len_reg <= (wr_cnt_reg < BUF_LEN) ?
                            wr_cnt_reg : BUF_LEN;
                        seq_idx_reg <= 8'h00;
                        gap_reg <= 9'h001;
                    end
                SQ_LEAD:
                    if (gap_reg == half_cyc)
                    begin
                        seq_state_reg <= SQ_BYTE;
                        eng_start_reg <= 1'b1;
                        eng_tx_reg <= data_buf_reg[seq_idx_reg];
                    end
                    else
                        gap_reg <= gap_reg + 9'h001;
                SQ_BYTE:
                    if (eng_done)
                    begin
                        if (seq_idx_reg + 8'h01 == seq_len_reg)
                        begin
                            seq_state_reg <= SQ_TAIL;
                            gap_reg <= 9'h001;
                        end
                        else
                        begin
                            eng_start_reg <= 1'b1;
                            eng_tx_reg <= data_buf_reg[seq_idx_reg + 8'h01];
                            seq_idx_reg <= seq_idx_reg + 8'h01;
                        end
                    end
                SQ_TAIL:
                    if (gap_reg == half_cyc)
                    begin
                        seq_state_reg <= SQ_IDLE;
                        busy_reg <= 1'b0;
                        sel_reg <= 4'h0;
                    end
                    else
                        gap_reg <= gap_reg + 9'h001;
                default:
                    seq_state_reg <= SQ_IDLE;
            endcase
        end
    end

    assign done_evt = (seq_state_reg == SQ_TAIL) && (gap_reg == half_cyc);

    // mode bits 3:2 are polarity and phase
    i2sm_spi_byte u_spi_byte (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .start(eng_start_reg),
        .tx_byte(eng_tx_reg),
        .cpol(cfg_reg[3]),
        .cpha(cfg_reg[2]),
        .half_cyc(half_cyc),
        .miso_s(miso_s),
        .sclk(spi_clock_out),
        .mosi(mosi),
        .rx_byte(eng_rx),
        .done(eng_done)
    );

    // selects low from two half bit periods before the first edge to after the last
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            ss_n_reg <= SEL_IDLE;
        else if (seq_state_reg != SQ_IDLE && !done_evt)
            ss_n_reg <= ~sel_reg;
        else
            ss_n_reg <= SEL_IDLE;
    end

    assign slave_select_0 = ss_n_reg[0];
    assign slave_select_1 = ss_n_reg[1];
    assign slave_select_2 = ss_n_reg[2];
    assign slave_select_3 = ss_n_reg[3];

    // interrupt: completion wins over a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            irq_n <= 1'b1;
        else if (done_evt)
            irq_n <= 1'b0;
        else if (clr_stb)
            irq_n <= 1'b1;
    end
endmodule : i2sm_top
`default_nettype wire
